// >>> bmdma_consts.svh
`ifndef BMDMA_CONSTS_SVH
`define BMDMA_CONSTS_SVH
// ==========================================
// Port map
`define BMDMA_PORT_C0_ADDR  8'h90
`define BMDMA_PORT_C0_COUNT 8'h91
`define BMDMA_PORT_C1_ADDR  8'h92
`define BMDMA_PORT_C1_COUNT 8'h93
`define BMDMA_PORT_C2_ADDR  8'h94
`define BMDMA_PORT_C2_COUNT 8'h95
`define BMDMA_PORT_C3_ADDR  8'h96
`define BMDMA_PORT_C3_COUNT 8'h97
// Port field: register index in low three bits
`define BMDMA_IDX_MSB       2
`define BMDMA_BASE_MSB      7
`define BMDMA_BASE_LSB      3
`define BMDMA_PORT_BASE     5'h12
// Reset values
`define BMDMA_REG_RESET     16'h0000
`define BMDMA_CTRL_RESET    8'h00
// Control port: bit 0 starts a move, bit 1 picks program memory as source, bit 2 as destination
`define BMDMA_PORT_CTRL     8'h98
`define BMDMA_CTRL_GO_BIT   0
`define BMDMA_CTRL_SRC_LSB  1
`define BMDMA_CTRL_DST_LSB  2
`endif

// >>> bmdma_pkg.sv
package bmdma_pkg;
  typedef enum logic [1:0] {
    BMDMA_IDLE  = 2'b00,
    BMDMA_READ  = 2'b01,
    BMDMA_WRITE = 2'b10
  } bmdma_state_e;
  typedef logic [15:0] bmdma_word_t;
endpackage

// >>> bmdma_regfile.sv
`include "bmdma_consts.svh"
// ==========================================
// Channel register store: eight 16-bit words, registered read
module bmdma_regfile #(
  parameter int unsigned NREG = 8
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Write side
  input  wire logic                 wr_en,
  input  wire logic                 wr_hi,
  input  wire logic [2:0]           wr_idx,
  input  wire logic [7:0]           wr_byte,
  // Read side
  input  wire logic [2:0]           rd_idx,
  output      bmdma_pkg::bmdma_word_t rd_word,
  // Whole store, seeds a move
  output      bmdma_pkg::bmdma_word_t [NREG-1:0] all_words
);
  import bmdma_pkg::*;
  typedef struct packed {
    bmdma_word_t [NREG-1:0] mem;
    bmdma_word_t            rd;
  } bmdma_rf_s;
  bmdma_rf_s st_r;
  bmdma_rf_s st_nxt;

  // Byte-lane write and registered read
  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      if (wr_hi) begin
        st_nxt.mem[wr_idx][15:8] = wr_byte;
      end else begin
        st_nxt.mem[wr_idx][7:0] = wr_byte;
      end
    end
    st_nxt.rd = st_nxt.mem[rd_idx];
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Read port and whole-store view, both from flops
  assign rd_word   = st_r.rd;
  assign all_words = st_r.mem;
endmodule // bmdma_regfile

// >>> bmdma_top.sv
// Function
// RL1: four channels, each a 16-bit transfer address and terminal count
// RL2: every channel register individually writable and reads back last value
// RL3: a 16-bit load takes two byte writes to one port
// RL4: byte toggle: first access low byte, second high; reset clears it
// RL5: channel registers decode at ports 90 to 97 in order
// RL6: fourth channel pair unused by system, still present at 96 and 97
// RL7: memory-to-memory block move between system and program memory
// RL8: destination equals source byte for byte, source untouched
`include "bmdma_consts.svh"
module bmdma_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // I/O port bus
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_port,
  input  wire logic [7:0]  io_wdata,
  output      logic [7:0]  io_rdata,
  output      logic        io_rvalid,
  // Memory master
  output      logic        mem_rd,
  output      logic        mem_wr,
  output      logic        mem_prog,
  output      logic [15:0] mem_addr,
  output      logic [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ack,
  // Status
  output      logic        busy
);
  import bmdma_pkg::*;

  // ==========================================
  // State
  typedef struct packed {
    // Port bus side: byte pointer and read return
    logic         ptr_hi;
    logic         rd_pend;
    logic         rd_hi;
    logic [7:0]   rdata;
    logic         rvalid;
    // Move engine side
    bmdma_state_e fsm;
    logic         src_prog;
    logic         dst_prog;
    bmdma_word_t  src;
    bmdma_word_t  dst;
    bmdma_word_t  left;
    logic         mrd;
    logic         mwr;
    logic         mprog;
    bmdma_word_t  maddr;
    logic [7:0]   mwdata;
    logic         busy;
  } bmdma_top_s;
  bmdma_top_s st_r;
  bmdma_top_s st_nxt;

  // Channel register file port values
  logic              rf_wr;
  logic [2:0]        rf_widx;
  logic [2:0]        rf_ridx;
  bmdma_word_t       rf_rword;
  bmdma_word_t [7:0] rf_words;
  logic              sel_chan;
  logic              sel_ctrl;
  logic              chan_ok;
  logic              last_byte;

  // Store slots that seed a move: channel 0 address, channel 1 address, channel 2 count
  localparam logic [2:0] SLOT_SRC = 3'h0;
  localparam logic [2:0] SLOT_DST = 3'h2;
  localparam logic [2:0] SLOT_LEN = 3'h5;

  // ==========================================
  // Port decode and arithmetic helpers
  function automatic logic is_chan(input logic [7:0] p);
    return p[`BMDMA_BASE_MSB:`BMDMA_BASE_LSB] == `BMDMA_PORT_BASE;
  endfunction

  // Next byte address, wraps at the top of memory
  function automatic bmdma_word_t step(input bmdma_word_t a);
    return a + 16'h0001;
  endfunction

  // Remaining length, one byte less
  function automatic bmdma_word_t less_one(input bmdma_word_t n);
    return n - 16'h0001;
  endfunction

  // Byte lane picked by the pointer
  function automatic logic [7:0] lane(input bmdma_word_t w, input logic hi);
    return hi ? w[15:8] : w[7:0];
  endfunction

  // RL5: port decode
  assign sel_chan  = is_chan(io_port);
  assign sel_ctrl  = io_port == `BMDMA_PORT_CTRL;
  // Channel access, refused while a move runs
  assign chan_ok   = sel_chan && !st_r.busy;
  // Final byte of the move is being written
  assign last_byte = st_r.left == 16'h0001;
  // RL3: byte writes to register
  assign rf_wr     = io_wr && chan_ok;
  assign rf_widx   = io_port[`BMDMA_IDX_MSB:0];
  assign rf_ridx   = st_r.busy ? 3'h0 : io_port[`BMDMA_IDX_MSB:0];

  // ==========================================
  // Channel register store
  // RL1: eight register store
  bmdma_regfile #(.NREG(8)) u_rf (
    .clk       (clk),
    .rstn      (rstn),
    .wr_en     (rf_wr),
    .wr_hi     (st_r.ptr_hi),
    .wr_idx    (rf_widx),
    .wr_byte   (io_wdata),
    .rd_idx    (rf_ridx),
    .rd_word   (rf_rword),
    .all_words (rf_words)
  );

  // ==========================================
  // Next state
  always_comb begin
    // Pulses drop unless set below
    st_nxt         = st_r;
    st_nxt.rvalid  = 1'b0;
    st_nxt.rd_pend = 1'b0;
    // RL4: toggle on each channel access
    if ((io_wr || io_rd) && chan_ok) begin
      st_nxt.ptr_hi = !st_r.ptr_hi;
    end
    // RL2: read back selected byte
    if (io_rd && chan_ok) begin
      st_nxt.rd_pend = 1'b1;
      st_nxt.rd_hi   = st_r.ptr_hi;
    end
    // Control port read returns busy in bit 0
    if (io_rd && sel_ctrl) begin
      st_nxt.rdata  = {7'h00, st_r.busy};
      st_nxt.rvalid = 1'b1;
    end
    // Stored word arrives one cycle after the access
    if (st_r.rd_pend) begin
      st_nxt.rdata  = lane(rf_rword, st_r.rd_hi);
      st_nxt.rvalid = 1'b1;
    end
    unique case (st_r.fsm)
      BMDMA_IDLE: begin
        // RL7: start move; channel 0 source, 1 dest, 2 count
        // Pointer restarts low so the next channel access is a low byte
        if (io_wr && sel_ctrl && io_wdata[`BMDMA_CTRL_GO_BIT]) begin
          st_nxt.fsm      = BMDMA_READ;
          st_nxt.busy     = 1'b1;
          st_nxt.src_prog = io_wdata[`BMDMA_CTRL_SRC_LSB];
          st_nxt.dst_prog = io_wdata[`BMDMA_CTRL_DST_LSB];
          st_nxt.src      = rf_words[SLOT_SRC];
          st_nxt.dst      = rf_words[SLOT_DST];
          st_nxt.left     = rf_words[SLOT_LEN];
          st_nxt.mrd      = 1'b1;
          st_nxt.mprog    = io_wdata[`BMDMA_CTRL_SRC_LSB];
          st_nxt.maddr    = rf_words[SLOT_SRC];
          st_nxt.ptr_hi   = 1'b0;
        end
      end
      BMDMA_READ: begin
        // RL8: read source only, byte goes out on the write unchanged
        if (mem_ack) begin
          st_nxt.mrd    = 1'b0;
          st_nxt.mwr    = 1'b1;
          st_nxt.mprog  = st_r.dst_prog;
          st_nxt.maddr  = st_r.dst;
          st_nxt.mwdata = mem_rdata;
          st_nxt.fsm    = BMDMA_WRITE;
        end
      end
      BMDMA_WRITE: begin
        // RL8: in-order copy, count down
        if (mem_ack) begin
          st_nxt.mwr  = 1'b0;
          st_nxt.src  = step(st_r.src);
          st_nxt.dst  = step(st_r.dst);
          st_nxt.left = less_one(st_r.left);
          // Last byte ends the move, else fetch the next source byte
          if (last_byte) begin
            st_nxt.fsm  = BMDMA_IDLE;
            st_nxt.busy = 1'b0;
          end else begin
            st_nxt.fsm   = BMDMA_READ;
            st_nxt.mrd   = 1'b1;
            st_nxt.mprog = st_r.src_prog;
            st_nxt.maddr = step(st_r.src);
          end
        end
      end
      default: begin
        // Unused state code: park idle
        st_nxt.fsm  = BMDMA_IDLE;
        st_nxt.busy = 1'b0;
        st_nxt.mrd  = 1'b0;
        st_nxt.mwr  = 1'b0;
      end
    endcase
  end

  // ==========================================
  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // Outputs from flops
  assign io_rdata  = st_r.rdata;
  assign io_rvalid = st_r.rvalid;
  assign mem_rd    = st_r.mrd;
  assign mem_wr    = st_r.mwr;
  assign mem_prog  = st_r.mprog;
  assign mem_addr  = st_r.maddr;
  assign mem_wdata = st_r.mwdata;
  assign busy      = st_r.busy;
endmodule // bmdma_top

// >>> bmdma_top_chk.sv
// ==========================
// Port checks on the block-move engine
module bmdma_top_chk (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_port,
  input wire logic [7:0]  io_wdata,
  input wire logic        io_rvalid,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  mem_rdata,
  input wire logic        mem_ack,
  input wire logic        busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  rvalid_once_a: assert property (io_rvalid |=> !io_rvalid) else $error("rvalid long");
  read_answer_a: assert property (io_rd && io_port[7:3] == 5'h12 && !busy |-> ##2 io_rvalid)
    else $error("no answer");
  rvalid_cause_a: assert property (io_rvalid |-> $past(io_rd) || $past(io_rd, 2))
    else $error("stray rvalid");
  move_start_a: assert property (io_wr && io_port == 8'h98 && io_wdata[0] && !busy
    |=> busy && mem_rd) else $error("no start");
  read_hold_a: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
    else $error("read dropped");
  req_excl_a: assert property (!(mem_rd && mem_wr)) else $error("read with write");
  byte_copy_a: assert property (mem_rd && mem_ack |=> mem_wr && mem_wdata == $past(mem_rdata))
    else $error("bad copy");
  idle_quiet_a: assert property (!busy |-> !mem_rd && !mem_wr) else $error("idle request");
endmodule // bmdma_top_chk

// >>> bmdma_mem_model.sv
// ==========================
// System and program memory partner
module bmdma_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic        mem_prog,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output      logic [7:0]  mem_rdata,
  output      logic        mem_ack
);
  logic [7:0] m [2][65536];
  logic       w = 1'b0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 8'h00;
  // Ack every second waiting cycle; stale read data toggles
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if ((mem_rd || mem_wr) && !mem_ack) begin
      w <= ~w;
      if (w) begin
        mem_ack <= 1'b1;
        if (mem_rd) mem_rdata <= m[mem_prog][mem_addr];
        if (mem_wr) m[mem_prog][mem_addr] <= mem_wdata;
      end
    end
  end
endmodule // bmdma_mem_model

// >>> bmdma_top_tb.sv
// ==========================
// Bench for the block-move engine
module bmdma_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rstn = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic [7:0]  io_port = 8'h00, io_wdata = 8'h00, io_rdata, mem_wdata, mem_rdata;
  logic        io_rvalid, mem_rd, mem_wr, mem_prog, mem_ack, busy;
  logic [15:0] mem_addr, got;
  int          failures = 0, check_count = 0, cyc = 0;
  always #25 clk = ~clk;
  bmdma_top uut (
    .clk       (clk),
    .rstn      (rstn),
    .io_wr     (io_wr),
    .io_rd     (io_rd),
    .io_port   (io_port),
    .io_wdata  (io_wdata),
    .io_rdata  (io_rdata),
    .io_rvalid (io_rvalid),
    .mem_rd    (mem_rd),
    .mem_wr    (mem_wr),
    .mem_prog  (mem_prog),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata),
    .mem_ack   (mem_ack),
    .busy      (busy)
  );
  bmdma_mem_model mem (
    .clk       (clk),
    .mem_rd    (mem_rd),
    .mem_wr    (mem_wr),
    .mem_prog  (mem_prog),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata),
    .mem_ack   (mem_ack)
  );
  task automatic close_out;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One byte access, strobe held one cycle
  task automatic acc(input logic w, input logic [7:0] p, input logic [7:0] d);
    @(negedge clk);
    {io_wr, io_rd, io_port, io_wdata} = {w, !w, p, d};
    @(negedge clk);
    {io_wr, io_rd} = 2'b00;
  endtask
  // One byte read; looks from the taking edge on, so a one-cycle control answer is seen too
  task automatic rd8(input logic [7:0] p, output logic [7:0] b);
    b = 8'hxx;
    @(negedge clk);
    {io_wr, io_rd, io_port} = {1'b0, 1'b1, p};
    repeat (3) begin
      @(posedge clk) #1;
      if (io_rvalid === 1'b1) b = io_rdata;
      if (io_rd) begin
        @(negedge clk);
        io_rd = 1'b0;
      end
    end
  endtask
  task automatic put16(input logic [7:0] p, input logic [15:0] v);
    acc(1'b1, p, v[7:0]);
    acc(1'b1, p, v[15:8]);
  endtask
  task automatic get16(input logic [7:0] p, output logic [15:0] v);
    rd8(p, v[7:0]);
    rd8(p, v[15:8]);
  endtask
  // Reset values, then distinct words in all six places
  task automatic t_map;
    for (int r = 0; r < 6; r++) begin
      get16(8'h90 + 8'(r), got);
      cmp(got, 16'h0000);
      put16(8'h90 + 8'(r), {8'h5a, 8'(r)});
    end
    for (int r = 0; r < 6; r++) begin
      get16(8'h90 + 8'(r), got);
      cmp(got, {8'h5a, 8'(r)});
    end
  endtask
  // Walking ones and zeros on each used register
  task automatic t_walk;
    logic [15:0] pat;
    for (int r = 0; r < 6; r++)
      for (int k = 0; k < 34; k++) begin
        pat = k < 16 ? 16'h1 << k : k < 32 ? ~(16'h1 << (k - 16)) : {16{k[0]}};
        put16(8'h90 + 8'(r), pat);
        get16(8'h90 + 8'(r), got);
        cmp(got, pat);
      end
  endtask
  task automatic t_move(input logic [2:0] ctl, input logic [15:0] n);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      mem.m[ctl[1]][16'h4000 + i] = 8'(i);
      mem.m[ctl[2]][16'h7000 + i] = 8'hee;
    end
    put16(8'h90, 16'h4000);
    put16(8'h92, 16'h7000);
    put16(8'h95, n);
    acc(1'b1, 8'h98, {5'h00, ctl});
    // Control port shows the move running; channel writes are refused meanwhile
    rd8(8'h98, b);
    cmp({8'h00, b}, 16'h0001);
    acc(1'b1, 8'h90, 8'hff);
    while (busy !== 1'b0) @(negedge clk);
    rd8(8'h98, b);
    cmp({8'h00, b}, 16'h0000);
    get16(8'h90, got);
    cmp(got, 16'h4000);
    for (int i = 0; i < n; i++)
      cmp({mem.m[ctl[2]][16'h7000 + i], mem.m[ctl[1]][16'h4000 + i]}, {2{8'(i)}});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      close_out;
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    t_map;
    t_walk;
    for (int d = 0; d < 4; d++)
      t_move({d[1:0], 1'b1}, d == 0 ? 16'h1000 : 16'h0040);
    close_out;
  end
endmodule // bmdma_top_tb
bind bmdma_top bmdma_top_chk chk (
  .clk       (clk),
  .rstn      (rstn),
  .io_wr     (io_wr),
  .io_rd     (io_rd),
  .io_port   (io_port),
  .io_wdata  (io_wdata),
  .io_rvalid (io_rvalid),
  .mem_rd    (mem_rd),
  .mem_wr    (mem_wr),
  .mem_addr  (mem_addr),
  .mem_wdata (mem_wdata),
  .mem_rdata (mem_rdata),
  .mem_ack   (mem_ack),
  .busy      (busy)
);
